/* File: design/otp_shadow.v */
`timescale 1ns/1ns
`include "otp_shadow_regs.vh"

module otp_shadow
#(
    parameter [127:0] RANDOM_VALUE = 128'h0123456789ABCDEF0F1E2D3C4B5A6978  // arbitrary
)
(
    input  wire       clk,
    input  wire       arst_n,
    input  wire       hw_reset_pin_n,
    input  wire       soft_reset,
    input  wire       cmd_valid,
    output wire       cmd_ready,
    input  wire [2:0] cmd_op,
    input  wire [9:0] cmd_addr,
    input  wire [7:0] cmd_wdata,
    output reg        rsp_valid,
    output reg  [7:0] rsp_rdata,
    output reg        rsp_err,
    output wire       busy
);

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE     = 2'h0;
    localparam [1:0] ST_NV_ERASE = 2'h1;
    localparam [1:0] ST_NV_PROG  = 2'h2;
    localparam [1:0] ST_OTP_PROG = 2'h3;

    // ------------------------------------------------------------
    // operation lengths in cycles
    // ------------------------------------------------------------
    localparam integer ERASE_CYC_N = `NV_ERASE_CYC;
    localparam integer NVPRG_CYC_N = `NV_PROG_CYC;
    localparam integer OTPRG_CYC_N = `OTP_PROG_CYC;
    localparam [7:0]   ERASE_CYC   = ERASE_CYC_N[7:0];
    localparam [7:0]   NVPRG_CYC   = NVPRG_CYC_N[7:0];
    localparam [7:0]   OTPRG_CYC   = OTPRG_CYC_N[7:0];

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    reg [7:0] otp_mem [0:`OTP_BYTES-1];
    reg [7:0] nv_reg   [0:5];
    reg [7:0] vol_reg  [0:7];

    reg [1:0] state_reg;
    reg [7:0] count_reg;
    reg [2:0] sel_reg;
    reg [7:0] data_reg;
    reg [9:0] addr_reg;
    reg       fail_reg;
    reg       hw_meta_reg;
    reg       hw_sync_reg;

    integer i;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function [7:0] nv_default;
        input [2:0] sel;
        begin
            case (sel)
                `REG_STATUS_ONE:   nv_default = `STATUS_ONE_NV_RST;
                `REG_CONFIG_ONE:   nv_default = `CONFIG_ONE_NV_RST;
                `REG_CONFIG_TWO:   nv_default = `CONFIG_TWO_NV_RST;
                `REG_CONFIG_THREE: nv_default = `CONFIG_THREE_NV_RST;
                `REG_CONFIG_FOUR:  nv_default = `CONFIG_FOUR_NV_RST;
                default:           nv_default = `DDR_LEARN_NV_RST;
            endcase
        end
    endfunction

    function [7:0] shipped_otp;
        input integer idx;
        begin
            if (idx <= `OTP_RANDOM_LAST)
                shipped_otp = RANDOM_VALUE[idx*8 +: 8];
            else
                shipped_otp = `OTP_ERASED;
        end
    endfunction

    // ------------------------------------------------------------
    // hardware reset pin synchroniser
    // ------------------------------------------------------------
    // starts low: commands wait until the pin is seen high
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hw_meta_reg <= 1'b0;
            hw_sync_reg <= 1'b0;
        end
        else
        begin
            hw_meta_reg <= hw_reset_pin_n;
            hw_sync_reg <= hw_meta_reg;
        end
    end

    // any reset kind holds commands off and reloads volatile copies
    wire reload = soft_reset | ~hw_sync_reg;

    // ------------------------------------------------------------
    // program check
    // ------------------------------------------------------------
    // region r lock: byte 0x010 + r/8, bit r%8
    wire [7:0] lock_byte   = otp_mem[{8'h00, cmd_addr[9:8]} + `OTP_LOCK_FIRST];
    wire       region_lock = ~lock_byte[cmd_addr[7:5]];
    wire       in_random   = (cmd_addr <= `OTP_RANDOM_LAST);
    wire       frozen      = vol_reg[`REG_CONFIG_ONE][`FREEZE_BIT];
    wire       prog_fail   = frozen
                           | region_lock
                           | (in_random & (cmd_wdata != `OTP_ERASED));

    wire is_idle = (state_reg == ST_IDLE);
    assign cmd_ready = is_idle & ~reload;
    assign busy      = ~is_idle;
    wire take = cmd_valid & cmd_ready;

    // ------------------------------------------------------------
    // sequencer, OTP array and nonvolatile copies
    // ------------------------------------------------------------
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= ST_IDLE;
            count_reg <= 8'h00;
            sel_reg   <= 3'h0;
            data_reg  <= 8'h00;
            addr_reg  <= 10'h000;
            fail_reg  <= 1'b0;
            for (i = 0; i < `OTP_BYTES; i = i + 1)
                otp_mem[i] <= shipped_otp(i);
            for (i = 0; i < 6; i = i + 1)
                nv_reg[i] <= nv_default(i[2:0]);
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (take && cmd_op == `OP_OTP_PROGRAM)
                    begin
                        addr_reg  <= cmd_addr;
                        data_reg  <= cmd_wdata;
                        fail_reg  <= prog_fail;
                        count_reg <= OTPRG_CYC;
                        state_reg <= ST_OTP_PROG;
                    end
                    else if (take && cmd_op == `OP_REG_WRITE_NV
                             && cmd_addr[2:0] <= `REG_DDR_LEARNING)
                    begin
                        sel_reg   <= cmd_addr[2:0];
                        // status one keeps its read-only default bits
                        data_reg  <= (cmd_addr[2:0] == `REG_STATUS_ONE)
                                   ? ((cmd_wdata & `STATUS_ONE_NV_WMASK)
                                      | (nv_reg[0] & ~`STATUS_ONE_NV_WMASK))
                                   : cmd_wdata;
                        count_reg <= ERASE_CYC;
                        state_reg <= ST_NV_ERASE;
                    end
                end
                ST_NV_ERASE:
                begin
                    // copy reads erased while the erase runs
                    nv_reg[sel_reg] <= `OTP_ERASED;
                    if (count_reg == 8'h01)
                    begin
                        count_reg <= NVPRG_CYC;
                        state_reg <= ST_NV_PROG;
                    end
                    else
                        count_reg <= count_reg - 8'h01;
                end
                ST_NV_PROG:
                begin
                    if (count_reg == 8'h01)
                    begin
                        nv_reg[sel_reg] <= data_reg;
                        state_reg       <= ST_IDLE;
                    end
                    else
                        count_reg <= count_reg - 8'h01;
                end
                ST_OTP_PROG:
                begin
                    if (count_reg == 8'h01)
                    begin
                        // ones into random bytes change nothing, failures change nothing
                        if (!fail_reg && addr_reg > `OTP_RANDOM_LAST)
                            otp_mem[addr_reg] <= otp_mem[addr_reg] & data_reg;
                        state_reg <= ST_IDLE;
                    end
                    else
                        count_reg <= count_reg - 8'h01;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // volatile copies
    // ------------------------------------------------------------
    wire nv_done  = (state_reg == ST_NV_PROG) && (count_reg == 8'h01);
    wire otp_done = (state_reg == ST_OTP_PROG) && (count_reg == 8'h01);
    wire vol_wr   = take && (cmd_op == `OP_REG_WRITE_VOL);

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (i = 0; i < 6; i = i + 1)
                vol_reg[i] <= nv_default(i[2:0]);
            vol_reg[`REG_STATUS_TWO] <= `STATUS_TWO_RST;
            vol_reg[`REG_ECC_STATUS] <= `ECC_STATUS_RST;
        end
        else
        begin
            if (reload)
            begin
                for (i = 0; i < 6; i = i + 1)
                    vol_reg[i] <= nv_reg[i];
                vol_reg[`REG_STATUS_TWO] <= `STATUS_TWO_RST;
                vol_reg[`REG_ECC_STATUS] <= `ECC_STATUS_RST;
            end
            // completions come last so a finishing operation wins over reload
            if (vol_wr)
                vol_reg[cmd_addr[2:0]] <= cmd_wdata;
            if (nv_done)
                vol_reg[sel_reg] <= data_reg;
            if (otp_done && fail_reg)
                vol_reg[`REG_STATUS_ONE][`PROG_ERR_BIT] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // responses
    // ------------------------------------------------------------
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            rsp_err   <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            rsp_err   <= 1'b0;
            if (take && cmd_op == `OP_OTP_READ)
            begin
                rsp_valid <= 1'b1;
                rsp_rdata <= otp_mem[cmd_addr];
            end
            else if (take && cmd_op == `OP_REG_READ)
            begin
                rsp_valid <= 1'b1;
                rsp_rdata <= vol_reg[cmd_addr[2:0]];
            end
            else if (take && (cmd_op == `OP_REG_WRITE_VOL
                     || (cmd_op == `OP_REG_WRITE_NV && cmd_addr[2:0] > `REG_DDR_LEARNING)
                     || cmd_op > `OP_REG_WRITE_NV))
            begin
                rsp_valid <= 1'b1;
                rsp_err   <= (cmd_op != `OP_REG_WRITE_VOL);
            end
            else if (nv_done)
                rsp_valid <= 1'b1;
            else if (otp_done)
            begin
                rsp_valid <= 1'b1;
                rsp_err   <= fail_reg;
            end
        end
    end

endmodule

/* File: design/otp_shadow_regs.vh */
`ifndef OTP_SHADOW_REGS_VH
`define OTP_SHADOW_REGS_VH

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define OP_OTP_READ        3'h0
`define OP_OTP_PROGRAM     3'h1
`define OP_REG_READ        3'h2
`define OP_REG_WRITE_VOL   3'h3
`define OP_REG_WRITE_NV    3'h4

// ------------------------------------------------------------
// register selects (cmd_addr[2:0] for register commands)
// ------------------------------------------------------------
`define REG_STATUS_ONE     3'h0
`define REG_CONFIG_ONE     3'h1
`define REG_CONFIG_TWO     3'h2
`define REG_CONFIG_THREE   3'h3
`define REG_CONFIG_FOUR    3'h4
`define REG_DDR_LEARNING   3'h5
`define REG_STATUS_TWO     3'h6
`define REG_ECC_STATUS     3'h7

// ------------------------------------------------------------
// OTP layout
// ------------------------------------------------------------
`define OTP_BYTES          1024
`define OTP_ADDR_W         10
`define OTP_RANDOM_LAST    10'h00F
`define OTP_LOCK_FIRST     10'h010
`define OTP_LOCK_LAST      10'h013
`define OTP_RSVD_FIRST     10'h014
`define OTP_RSVD_LAST      10'h01F
`define OTP_REGION_LSB     5
`define OTP_ERASED         8'hFF

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define FREEZE_BIT         0
`define PROG_ERR_BIT       6

// ------------------------------------------------------------
// shipped nonvolatile values, volatile reset values and write mask
// ------------------------------------------------------------
`define STATUS_ONE_NV_RST  8'h00
`define CONFIG_ONE_NV_RST  8'h00
`define CONFIG_TWO_NV_RST  8'h08
`define CONFIG_THREE_NV_RST 8'h00
`define CONFIG_FOUR_NV_RST 8'h08
`define DDR_LEARN_NV_RST   8'h00
`define STATUS_TWO_RST     8'h00
`define ECC_STATUS_RST     8'h00
`define STATUS_ONE_NV_WMASK 8'h9C

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS      50
`define NV_ERASE_NS        1000
`define NV_PROG_NS         1000
`define OTP_PROG_NS        500
`define NV_ERASE_CYC       ((`NV_ERASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NV_PROG_CYC        ((`NV_PROG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OTP_PROG_CYC       ((`OTP_PROG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: verif/otp_shadow_checker.sv */
`timescale 1ns/1ns
`include "otp_shadow_regs.vh"
module otp_shadow_checker
(
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       hw_reset_pin_n,
    input wire logic       soft_reset,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic [2:0] cmd_op,
    input wire logic [9:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic       rsp_valid,
    input wire logic [7:0] rsp_rdata,
    input wire logic       rsp_err,
    input wire logic       busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire take = cmd_valid && cmd_ready;

    sequence prog_take;
        take && cmd_op == `OP_OTP_PROGRAM;
    endsequence
    sequence prog_busy;
        ##1 busy [*8];
    endsequence

    reg_read_a: assert property (take && cmd_op == `OP_REG_READ |=> rsp_valid && !rsp_err)
        else $error("register read not answered");
    otp_read_a: assert property (take && cmd_op == `OP_OTP_READ |=> rsp_valid)
        else $error("otp read not answered");
    prog_busy_a: assert property (prog_take |-> prog_busy)
        else $error("program not busy");
    prog_answer_a: assert property (prog_take |-> ##[1:11] rsp_valid)
        else $error("program not answered");
    random_zero_a: assert property (prog_take and (cmd_addr <= `OTP_RANDOM_LAST
        && cmd_wdata != 8'hFF) |-> ##[1:11] (rsp_valid && rsp_err))
        else $error("zero into random value accepted");
    nv_answer_a: assert property (take && cmd_op == `OP_REG_WRITE_NV |-> ##[1:60] rsp_valid)
        else $error("nonvolatile write not answered");
    bad_op_a: assert property (take && cmd_op > 3'h4 |=> rsp_valid && rsp_err)
        else $error("invalid op not refused");
    busy_ready_a: assert property (busy |-> !cmd_ready)
        else $error("ready while busy");
    err_valid_a: assert property (rsp_err |-> rsp_valid)
        else $error("error without valid");
    soft_block_a: assert property (soft_reset |-> ##[0:1] !cmd_ready)
        else $error("ready during soft reset");
    hw_block_a: assert property ($fell(hw_reset_pin_n) |-> ##[1:3] !cmd_ready)
        else $error("ready during pin reset");
endmodule

bind otp_shadow otp_shadow_checker i_otp_shadow_checker (.clk(clk), .arst_n(arst_n),
    .hw_reset_pin_n(hw_reset_pin_n), .soft_reset(soft_reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .busy(busy));

/* File: verif/spi_host_model.sv */
`timescale 1ns/1ns
module spi_host_model
(
    input  wire logic       clk,
    input  wire logic       cmd_ready,
    input  wire logic       rsp_valid,
    input  wire logic [7:0] rsp_rdata,
    input  wire logic       rsp_err,
    output logic            cmd_valid,
    output logic      [2:0] cmd_op,
    output logic      [9:0] cmd_addr,
    output logic      [7:0] cmd_wdata
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_op    = 3'h0;
        cmd_addr  = 10'h000;
        cmd_wdata = 8'h00;
    end

    // hold request until taken, then wait for the answer
    task automatic xfer(input logic [2:0] op, input logic [9:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic er);
        int n;
        n = 0;
        @(negedge clk);
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_addr = ~a;
        cmd_wdata = ~d;
        while (rsp_valid !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        rd = (n < 200) ? rsp_rdata : 'x;
        er = (n < 200) ? rsp_err : 1'bx;
    endtask
endmodule

/* File: verif/otp_shadow_tb.sv */
`timescale 1ns/1ns
`include "otp_shadow_regs.vh"
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module otp_shadow_tb;
    localparam [127:0] RND = 128'h5A3C96E1F00F1234ABCD8765C3A50FF0; // arbitrary
    logic       clk, arst_n, hw_reset_pin_n, soft_reset;
    wire        cmd_valid, cmd_ready, rsp_valid, rsp_err, busy;
    wire  [2:0] cmd_op;
    wire  [9:0] cmd_addr;
    wire  [7:0] cmd_wdata, rsp_rdata;
    logic [7:0] rd;
    logic       er;
    int         n_fail, n_compared, cyc;
    logic [9:0] ff_a[6] = '{10'h010, 10'h013, 10'h014, 10'h01F, 10'h020, 10'h3FF};
    logic [9:0] pa[10] = '{10'h020, 10'h020, 10'h003, 10'h003, 10'h015,
                           10'h010, 10'h021, 10'h013, 10'h3FF, 10'h040};
    logic [7:0] pd[10] = '{8'hA5, 8'h0F, 8'hFF, 8'h7F, 8'h00, 8'hFD, 8'h00, 8'h7F, 8'h00, 8'h3C};
    logic       pe[10] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] pr[10] = '{8'hA5, 8'h05, RND[31:24], RND[31:24], 8'h00,
                           8'hFD, 8'hFF, 8'h7F, 8'hFF, 8'h3C};

    otp_shadow #(.RANDOM_VALUE(RND)) i_otp_shadow (.clk(clk), .arst_n(arst_n),
        .hw_reset_pin_n(hw_reset_pin_n), .soft_reset(soft_reset), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .busy(busy));
    spi_host_model i_spi_host_model (.clk(clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task run(input logic [2:0] o, input logic [9:0] a, input logic [7:0] d);
        i_spi_host_model.xfer(o, a, d, rd, er);
        if (er === 1'bx)
        begin
            n_fail++;
            $display("unexpected at %0t: command not answered", $time);
        end
    endtask

    task pulse_reset(input bit pin);
        @(negedge clk);
        if (pin)
            hw_reset_pin_n = 1'b0;
        else
            soft_reset = 1'b1;
        repeat (3) @(negedge clk);
        hw_reset_pin_n = 1'b1;
        soft_reset = 1'b0;
    endtask

    task tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        arst_n = 1'b0;
        hw_reset_pin_n = 1'b1;
        soft_reset = 1'b0;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            run(`OP_OTP_READ, 10'(i), 8'h00);
            `CMP(rd, RND[8*i +: 8])
        end
        foreach (ff_a[i])
        begin
            run(`OP_OTP_READ, ff_a[i], 8'h00);
            `CMP(rd, `OTP_ERASED)
        end
        run(`OP_REG_READ, 10'(`REG_CONFIG_TWO), 8'h00);
        `CMP(rd, `CONFIG_TWO_NV_RST)
        $display("shipped image done");
        // each lock byte is followed by a write into the region it locks, which must fail
        for (int i = 0; i < 10; i++)
        begin
            run(`OP_OTP_PROGRAM, pa[i], pd[i]);
            `CMP(er, pe[i])
            run(`OP_OTP_READ, pa[i], 8'h00);
            `CMP(rd, pr[i])
        end
        run(`OP_REG_READ, 10'(`REG_STATUS_ONE), 8'h00);
        `CMP(rd[`PROG_ERR_BIT], 1'b1)
        $display("otp program done");
        run(`OP_REG_WRITE_NV, 10'(`REG_CONFIG_TWO), 8'h55);
        `CMP(er, 1'b0)
        run(`OP_REG_READ, 10'(`REG_CONFIG_TWO), 8'h00);
        `CMP(rd, 8'h55)
        run(`OP_REG_WRITE_VOL, 10'(`REG_CONFIG_TWO), 8'h33);
        run(`OP_REG_READ, 10'(`REG_CONFIG_TWO), 8'h00);
        `CMP(rd, 8'h33)
        run(`OP_REG_WRITE_VOL, 10'(`REG_STATUS_TWO), 8'hAA);
        pulse_reset(1'b0);
        run(`OP_REG_READ, 10'(`REG_CONFIG_TWO), 8'h00);
        `CMP(rd, 8'h55)
        run(`OP_REG_READ, 10'(`REG_STATUS_ONE), 8'h00);
        `CMP(rd[`PROG_ERR_BIT], 1'b0)
        run(`OP_REG_READ, 10'(`REG_STATUS_TWO), 8'h00);
        `CMP(rd, `STATUS_TWO_RST)
        run(`OP_REG_WRITE_VOL, 10'(`REG_CONFIG_TWO), 8'h33);
        run(`OP_REG_WRITE_VOL, 10'(`REG_STATUS_TWO), 8'hAA);
        pulse_reset(1'b1);
        run(`OP_REG_READ, 10'(`REG_CONFIG_TWO), 8'h00);
        `CMP(rd, 8'h55)
        run(`OP_REG_READ, 10'(`REG_STATUS_TWO), 8'h00);
        `CMP(rd, `STATUS_TWO_RST)
        run(3'h5, 10'h000, 8'h00);
        `CMP(er, 1'b1)
        run(`OP_REG_WRITE_NV, 10'(`REG_STATUS_TWO), 8'h01);
        `CMP(er, 1'b1)
        $display("register copies done");
        run(`OP_REG_WRITE_VOL, 10'(`REG_CONFIG_ONE), 8'h01);
        run(`OP_OTP_PROGRAM, 10'h041, 8'h00);
        `CMP(er, 1'b1)
        run(`OP_OTP_READ, 10'h041, 8'h00);
        `CMP(rd, `OTP_ERASED)
        pulse_reset(1'b0);
        run(`OP_REG_READ, 10'(`REG_CONFIG_ONE), 8'h00);
        `CMP(rd, `CONFIG_ONE_NV_RST)
        $display("freeze done");
        run(`OP_REG_WRITE_NV, 10'(`REG_STATUS_ONE), 8'hFF);
        `CMP(er, 1'b0)
        run(`OP_REG_READ, 10'(`REG_STATUS_ONE), 8'h00);
        `CMP(rd, `STATUS_ONE_NV_WMASK | (`STATUS_ONE_NV_RST & ~`STATUS_ONE_NV_WMASK))
        pulse_reset(1'b1);
        run(`OP_REG_READ, 10'(`REG_STATUS_ONE), 8'h00);
        `CMP(rd, `STATUS_ONE_NV_WMASK | (`STATUS_ONE_NV_RST & ~`STATUS_ONE_NV_WMASK))
        $display("status one mask done");
        tally_and_finish();
    end
endmodule
